// File: tcb_pkg.sv
/*
 Shared constants and carrier types of the trace capture buffer.
 Assumes one 40 MHz clock and a 32-bit register port with 8-bit addresses.
*/
package tcb_pkg;
    // Bus and stream widths
    localparam int AW      = 8;
    localparam int DW      = 32;
    localparam int PA_W    = 40;
    localparam int ID_W    = 7;
    localparam int TD_W    = 25;
    localparam int PTR_W   = 16;
    localparam int RAM_AW  = 6;
    localparam int RAM_DEP = 64;
    localparam int PG_N    = 4;
    localparam int PG_IW   = 2;
    localparam int PG_OW   = 10;
    localparam int PFN_W   = 28;
    localparam int STS_W   = 3;
    localparam int CTL_W   = 5;

    // Trigger source id on the trace bus
    localparam logic [ID_W-1:0] TRIG_ID = 7'h7d;

    // Register offsets
    localparam logic [AW-1:0] OFS_CTRL  = 8'h00;
    localparam logic [AW-1:0] OFS_STS   = 8'h04;
    localparam logic [AW-1:0] OFS_MASK  = 8'h08;
    localparam logic [AW-1:0] OFS_BASEL = 8'h0c;
    localparam logic [AW-1:0] OFS_BASEH = 8'h10;
    localparam logic [AW-1:0] OFS_SIZE  = 8'h14;
    localparam logic [AW-1:0] OFS_WMARK = 8'h18;
    localparam logic [AW-1:0] OFS_WPTR  = 8'h1c;
    localparam logic [AW-1:0] OFS_FILL  = 8'h20;
    localparam logic [AW-1:0] OFS_RAMRD = 8'h24;
    localparam logic [3:0]    PG_SEL    = 4'h4;

    // Control bits
    localparam int C_EN   = 0;
    localparam int C_RAM  = 1;
    localparam int C_CIRC = 2;
    localparam int C_SCAT = 3;
    localparam int C_STOP = 4;

    // Status bits (sticky, write one to clear) and stopped (read only)
    localparam int S_WRAP  = 0;
    localparam int S_WMARK = 1;
    localparam int S_TRIG  = 2;
    localparam int S_STOPD = 3;

    // Reset values
    localparam logic [CTL_W-1:0] CTRL_RST = 5'h04;
    localparam logic [PTR_W-1:0] SIZE_RST = 16'h0040;

    typedef struct packed {
        logic [ID_W-1:0] id;
        logic [TD_W-1:0] data;
    } tcb_word_t;

    typedef struct packed {
        logic [CTL_W-1:0]            ctrl;
        logic [STS_W-1:0]            sts;
        logic [STS_W-1:0]            mask;
        logic [PA_W-1:0]             base;
        logic [PTR_W-1:0]            size;
        logic [PTR_W-1:0]            wmark;
        logic [PTR_W-1:0]            woff;
        logic [PTR_W-1:0]            fill;
        logic                        stopped;
        logic [PG_N-1:0][PFN_W-1:0]  pfn;
        logic [RAM_AW-1:0]           rptr;
        logic                        mvalid;
        logic [PA_W-1:0]             maddr;
        tcb_word_t                   mdata;
        logic [DW-1:0]               rdata;
    } tcb_state_t;
endpackage : tcb_pkg

// File: tcb_capture.sv
/*
 Trace capture buffer: takes formatted words from the trace bus funnel,
 stores them in a local RAM or writes them to system memory.
 Assumes the memory side holds mem_valid until mem_ready, the trace side
 holds tr_valid until tr_ready, and software keeps SIZE within RAM depth
 in RAM mode and within four pages in scatter mode.
*/
`timescale 1ns/1ps
module tcb_capture #(
    parameter logic [3:0] STREAM_ID = 4'h1 // Arbitrary default
) (
    // Clock, enable, reset
    input  wire logic                    sys_clk,
    input  wire logic                    ce,
    input  wire logic                    rst_n,
    // Register port
    input  wire logic [tcb_pkg::AW-1:0]  reg_addr,
    input  wire logic [tcb_pkg::DW-1:0]  reg_wdata,
    input  wire logic                    reg_wr,
    input  wire logic                    reg_rd,
    output logic      [tcb_pkg::DW-1:0]  reg_rdata,
    // Trace bus input
    input  wire logic                    tr_valid,
    input  wire tcb_pkg::tcb_word_t      tr_word,
    output logic                         tr_ready,
    // Dedicated event 0 line
    input  wire logic                    evt0,
    // System memory write port
    output logic                         mem_valid,
    output logic      [tcb_pkg::PA_W-1:0] mem_addr,
    output tcb_pkg::tcb_word_t           mem_data,
    output logic      [3:0]              mem_stream,
    output logic                         mem_ns,
    input  wire logic                    mem_ready,
    // Interrupt
    output logic                         irq
);
    tcb_pkg::tcb_state_t s_q;
    tcb_pkg::tcb_state_t s_d;

    // Local trace RAM
    tcb_pkg::tcb_word_t ram [tcb_pkg::RAM_DEP];

    logic acc;
    logic is_trig;
    logic trig;
    logic store;
    logic last;
    logic to_ram;
    logic [tcb_pkg::PTR_W-1:0] fill_nx;
    logic [tcb_pkg::PG_IW-1:0] pg_idx;
    logic [tcb_pkg::PG_IW-1:0] wr_pg;

    // Accept while enabled and the memory slot is free or unused; stopped capture drains and drops input.
    // No handshake while frozen, else a word would be taken and never stored.
    assign to_ram   = s_q.ctrl[tcb_pkg::C_RAM];
    assign tr_ready = ce && s_q.ctrl[tcb_pkg::C_EN]
                      && (s_q.stopped || to_ram || !s_q.mvalid || mem_ready);
    assign acc      = tr_valid && tr_ready;
    assign is_trig  = acc && (tr_word.id == tcb_pkg::TRIG_ID);
    assign trig     = is_trig || evt0;
    assign store    = acc && !is_trig && !s_q.stopped;
    assign last     = s_q.woff == s_q.size - 16'h0001;
    assign fill_nx  = s_q.fill + 16'h0001;
    assign pg_idx   = s_q.woff[tcb_pkg::PG_OW +: tcb_pkg::PG_IW];
    assign wr_pg    = reg_addr[3:2];

    // Next-state logic
    always_comb begin
        s_d       = s_q;
        s_d.rdata = '0;
        if (mem_ready) begin
            s_d.mvalid = 1'b0;
        end

        // Register writes come first so a same-cycle event still sets
        if (reg_wr) begin
            if (reg_addr[7:4] == tcb_pkg::PG_SEL) begin
                s_d.pfn[wr_pg] = reg_wdata[tcb_pkg::PFN_W-1:0];
            end
            unique case (reg_addr)
                tcb_pkg::OFS_CTRL: begin
                    s_d.ctrl = reg_wdata[tcb_pkg::CTL_W-1:0];
                    // Fresh start on enable: empty buffer, capture running
                    if (reg_wdata[tcb_pkg::C_EN] && !s_q.ctrl[tcb_pkg::C_EN]) begin
                        s_d.woff    = '0;
                        s_d.fill    = '0;
                        s_d.stopped = 1'b0;
                    end
                end
                tcb_pkg::OFS_STS:   s_d.sts   = s_q.sts & ~reg_wdata[tcb_pkg::STS_W-1:0];
                tcb_pkg::OFS_MASK:  s_d.mask  = reg_wdata[tcb_pkg::STS_W-1:0];
                tcb_pkg::OFS_BASEL: s_d.base[31:0] = reg_wdata;
                tcb_pkg::OFS_BASEH: s_d.base[tcb_pkg::PA_W-1:32] = reg_wdata[7:0];
                tcb_pkg::OFS_SIZE:  s_d.size  = reg_wdata[tcb_pkg::PTR_W-1:0];
                tcb_pkg::OFS_WMARK: s_d.wmark = reg_wdata[tcb_pkg::PTR_W-1:0];
                tcb_pkg::OFS_RAMRD: s_d.rptr  = reg_wdata[tcb_pkg::RAM_AW-1:0];
                default: ;
            endcase
        end

        // Register reads, answered one cycle later
        if (reg_rd) begin
            if (reg_addr[7:4] == tcb_pkg::PG_SEL) begin
                s_d.rdata = {4'h0, s_q.pfn[wr_pg]};
            end
            unique case (reg_addr)
                tcb_pkg::OFS_CTRL:  s_d.rdata = {27'h0, s_q.ctrl};
                tcb_pkg::OFS_STS: begin
                    s_d.rdata = {28'h0, s_q.stopped, s_q.sts};
                end
                tcb_pkg::OFS_MASK:  s_d.rdata = {29'h0, s_q.mask};
                tcb_pkg::OFS_BASEL: s_d.rdata = s_q.base[31:0];
                tcb_pkg::OFS_BASEH: s_d.rdata = {24'h0, s_q.base[tcb_pkg::PA_W-1:32]};
                tcb_pkg::OFS_SIZE:  s_d.rdata = {16'h0, s_q.size};
                tcb_pkg::OFS_WMARK: s_d.rdata = {16'h0, s_q.wmark};
                tcb_pkg::OFS_WPTR:  s_d.rdata = {16'h0, s_q.woff};
                tcb_pkg::OFS_FILL:  s_d.rdata = {16'h0, s_q.fill};
                tcb_pkg::OFS_RAMRD: begin
                    // Read drains the RAM in order, pointer steps itself
                    s_d.rdata = ram[s_q.rptr];
                    s_d.rptr  = s_q.rptr + 6'h01;
                end
                default: ;
            endcase
        end

        // Store one formatted word
        if (store) begin
            if (!to_ram) begin
                s_d.mvalid = 1'b1;
                s_d.mdata  = tr_word;
                if (s_q.ctrl[tcb_pkg::C_SCAT]) begin
                    // Stage one here; stage two lies in the memory translation
                    s_d.maddr = {s_q.pfn[pg_idx], s_q.woff[tcb_pkg::PG_OW-1:0],
                                 2'b00};
                end else begin
                    s_d.maddr = s_q.base + {22'h0, s_q.woff, 2'b00};
                end
            end
            if (s_q.fill != s_q.size) begin
                s_d.fill = fill_nx;
            end
            if (fill_nx == s_q.wmark) begin
                s_d.sts[tcb_pkg::S_WMARK] = 1'b1;
            end
            if (last) begin
                s_d.woff = '0;
                if (s_q.ctrl[tcb_pkg::C_CIRC]) begin
                    s_d.sts[tcb_pkg::S_WRAP] = 1'b1;
                end else begin
                    // Linear mode ends when the buffer is full
                    s_d.stopped = 1'b1;
                end
            end else begin
                s_d.woff = s_q.woff + 16'h0001;
            end
        end

        // Stop event from the trace unit
        if (trig && s_q.ctrl[tcb_pkg::C_EN]) begin
            s_d.sts[tcb_pkg::S_TRIG] = 1'b1;
            if (s_q.ctrl[tcb_pkg::C_STOP]) begin
                s_d.stopped = 1'b1;
            end
        end
    end

    // State register; only the system reset clears it, warm reset not wired
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_q       <= '0;
            s_q.ctrl  <= tcb_pkg::CTRL_RST;
            s_q.size  <= tcb_pkg::SIZE_RST;
            s_q.wmark <= tcb_pkg::SIZE_RST;
        end else if (ce) begin
            s_q <= s_d;
        end
    end

    // RAM write, no reset on storage
    always_ff @(posedge sys_clk) begin
        if (ce && store && to_ram) begin
            ram[s_q.woff[tcb_pkg::RAM_AW-1:0]] <= tr_word;
        end
    end

    // Outputs
    assign reg_rdata  = s_q.rdata;
    assign mem_valid  = s_q.mvalid && ce; // Silent while frozen, no double write
    assign mem_addr   = s_q.maddr;
    assign mem_data   = s_q.mdata;
    assign mem_stream = STREAM_ID;
    assign mem_ns     = 1'b1;
    // Level line, fit for a shared interrupt input
    assign irq        = |(s_q.sts & s_q.mask);

    // Checks
    default clocking dc @(posedge sys_clk iff ce);
    endclocking
    default disable iff (!rst_n);

    circ_wrap_a: assert property (
        store && last && s_q.ctrl[tcb_pkg::C_CIRC] && !reg_wr
        |=> s_q.woff == '0 && s_q.sts[tcb_pkg::S_WRAP] && !s_q.stopped)
        else $error("circular wrap not taken");

    lin_full_a: assert property (
        store && last && !s_q.ctrl[tcb_pkg::C_CIRC] && !reg_wr
        |=> s_q.stopped ##1 !store)
        else $error("linear buffer did not stop");

    contig_addr_a: assert property (
        store && !to_ram && !s_q.ctrl[tcb_pkg::C_SCAT]
        |=> mem_valid && mem_addr == $past(s_q.base) + {22'h0, $past(s_q.woff), 2'b00})
        else $error("contiguous address wrong");

    scat_addr_a: assert property (
        store && !to_ram && s_q.ctrl[tcb_pkg::C_SCAT]
        |=> mem_addr[11:2] == $past(s_q.woff[9:0])
            && mem_addr[tcb_pkg::PA_W-1:12] == $past(s_q.pfn[pg_idx]))
        else $error("scatter address wrong");

    pack_id_a: assert property (
        store && !to_ram |=> mem_data.id == $past(tr_word.id)
                             && mem_data.data == $past(tr_word.data))
        else $error("source id not stored");

    trig_drop_a: assert property (
        is_trig && !reg_wr |=> $stable(s_q.woff) && $stable(s_q.fill))
        else $error("trigger word was stored");

    trig_stop_a: assert property (
        trig && s_q.ctrl[tcb_pkg::C_EN] && s_q.ctrl[tcb_pkg::C_STOP] && !reg_wr
        |=> s_q.stopped && s_q.sts[tcb_pkg::S_TRIG] ##1 !store)
        else $error("trigger did not stop capture");

    wmark_set_a: assert property (
        store && fill_nx == s_q.wmark |=> s_q.sts[tcb_pkg::S_WMARK] ##1 irq || !s_q.mask[1])
        else $error("watermark flag missing");

    mem_hold_a: assert property (
        mem_valid && !mem_ready |=> mem_valid && $stable(mem_addr))
        else $error("memory request dropped");

    rd_late_a: assert property (
        reg_rd && reg_addr == tcb_pkg::OFS_WPTR |=> reg_rdata[15:0] == $past(s_q.woff))
        else $error("read data not one cycle late");

    // Frozen cycles offer no handshake and move no state
    ce_hold_a: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        !ce |-> (!tr_ready && !mem_valid) ##1 $stable(s_q))
        else $error("state moved while clock enable low");

    // Each word goes to memory once only
    mem_once_a: assert property (
        mem_valid && mem_ready && !store |=> !mem_valid)
        else $error("memory word offered twice");

    // Local RAM keeps the source id beside the payload
    ram_write_a: assert property (
        store && to_ram |=> ram[$past(s_q.woff[tcb_pkg::RAM_AW-1:0])] == $past(tr_word))
        else $error("RAM word lost its source id");

    // Draining reads walk the RAM in order
    rptr_step_a: assert property (
        reg_rd && reg_addr == tcb_pkg::OFS_RAMRD && !reg_wr
        |=> s_q.rptr == $past(s_q.rptr) + 6'h01)
        else $error("RAM read pointer did not step");

    // Status group: write one clears when no event competes
    sts_clear_a: assert property (
        reg_wr && reg_addr == tcb_pkg::OFS_STS && !store && !trig
        |=> (s_q.sts & $past(reg_wdata[tcb_pkg::STS_W-1:0])) == '0)
        else $error("status bit not cleared");

    // Flags only fall on a status write
    sts_sticky_a: assert property (
        !(reg_wr && reg_addr == tcb_pkg::OFS_STS)
        |=> (s_q.sts & $past(s_q.sts)) == $past(s_q.sts))
        else $error("status bit dropped without a clear");

    // Wrap with the flag masked in raises the line at once
    wrap_irq_a: assert property (
        store && last && s_q.ctrl[tcb_pkg::C_CIRC] && s_q.mask[tcb_pkg::S_WRAP]
        && !reg_wr |=> irq)
        else $error("wrap interrupt missing");

    // Linear buffer ends without a wrap flag
    lin_nowrap_a: assert property (
        store && last && !s_q.ctrl[tcb_pkg::C_CIRC] && !s_q.sts[tcb_pkg::S_WRAP]
        |=> !s_q.sts[tcb_pkg::S_WRAP])
        else $error("linear buffer flagged a wrap");

    // Enabling restarts an empty, running buffer
    en_clear_a: assert property (
        reg_wr && reg_addr == tcb_pkg::OFS_CTRL && reg_wdata[tcb_pkg::C_EN]
        && !s_q.ctrl[tcb_pkg::C_EN]
        |=> s_q.woff == '0 && s_q.fill == '0 && !s_q.stopped)
        else $error("enable did not restart the buffer");

    // Overwriting in circular mode leaves the fill level at the size
    fill_sat_a: assert property (
        store && s_q.fill == s_q.size && !reg_wr |=> $stable(s_q.fill))
        else $error("fill level ran past the size");

    // Stop group: only software restarts capture
    stop_hold_a: assert property (
        s_q.stopped && !(reg_wr && reg_addr == tcb_pkg::OFS_CTRL) |=> s_q.stopped)
        else $error("capture restarted on its own");

    // A stopped buffer keeps draining so the funnel never backs up
    stop_drain_a: assert property (
        s_q.stopped && s_q.ctrl[tcb_pkg::C_EN] |-> tr_ready)
        else $error("stopped buffer stalled the trace bus");

    // Trigger id is seen even without stop on trigger
    trig_flag_a: assert property (
        is_trig && s_q.ctrl[tcb_pkg::C_EN] && !reg_wr |=> s_q.sts[tcb_pkg::S_TRIG])
        else $error("trigger id not recorded");

    // Dedicated event line counts as a stop event
    evt_flag_a: assert property (
        evt0 && s_q.ctrl[tcb_pkg::C_EN] && !reg_wr |=> s_q.sts[tcb_pkg::S_TRIG])
        else $error("event line not recorded");

    // Trigger word never reaches memory
    trig_no_mem_a: assert property (
        is_trig && !s_q.mvalid |=> !mem_valid)
        else $error("trigger word sent to memory");

    // Register group: page frames land in the addressed slot
    page_write_a: assert property (
        reg_wr && reg_addr[7:4] == tcb_pkg::PG_SEL
        |=> s_q.pfn[$past(wr_pg)] == $past(reg_wdata[tcb_pkg::PFN_W-1:0]))
        else $error("page frame not written");

    // Upper address byte reaches bit 39
    base_high_a: assert property (
        reg_wr && reg_addr == tcb_pkg::OFS_BASEH
        |=> s_q.base[tcb_pkg::PA_W-1:32] == $past(reg_wdata[7:0]))
        else $error("upper address bits not kept");

    // Read data stand only in the cycle after the strobe
    rd_idle_a: assert property (
        !reg_rd |=> reg_rdata == '0)
        else $error("read data outside its cycle");

    wrap_c:  cover property (store && last && s_q.ctrl[tcb_pkg::C_CIRC]);
    stop_c:  cover property (trig && s_q.ctrl[tcb_pkg::C_STOP] ##1 s_q.stopped);
    wmark_c: cover property (s_q.sts[tcb_pkg::S_WMARK] && irq);
    scat_c:  cover property (store && s_q.ctrl[tcb_pkg::C_SCAT] && pg_idx == 2'h1);
    ce_c:    cover property (@(posedge sys_clk) !ce && tr_valid);
endmodule : tcb_capture

// File: tcb_mem_model.sv
/* Memory partner of the capture buffer: takes write requests, keeps the last.
   Assumes the buffer's clock and reset. */
`timescale 1ns/1ps
module tcb_mem_model (
    // Clock, reset, pacing
    input  wire logic                     sys_clk,
    input  wire logic                     rst_n,
    input  wire logic                     slow,
    // Write port
    input  wire logic                     mem_valid,
    input  wire logic [tcb_pkg::PA_W-1:0] mem_addr,
    input  wire tcb_pkg::tcb_word_t       mem_data,
    output logic                          mem_ready,
    // Last accepted write
    output logic [tcb_pkg::PA_W-1:0]      last_addr,
    output tcb_pkg::tcb_word_t            last_data,
    output int                            cnt
);
    logic [1:0] ph_q;
    // Slow pacing gives ready one cycle in four, to back-pressure the buffer
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ph_q      <= 2'h0;
            mem_ready <= 1'b0;
            cnt       <= 0;
            last_addr <= '0;
            last_data <= '0;
        end else begin
            ph_q      <= ph_q + 2'h1;
            mem_ready <= !slow || ph_q == 2'h2;
            if (mem_valid && mem_ready) begin
                last_addr <= mem_addr;
                last_data <= mem_data;
                cnt       <= cnt + 1;
            end
        end
    end
endmodule : tcb_mem_model

// File: tcb_tb.sv
/* Self-checking bench of the trace capture buffer.
   Assumes tcb_pkg, tcb_capture and tcb_mem_model are compiled first. */
`timescale 1ns/1ps
module testbench;
    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic [31:0] exp;
    } tcb_row_t;
    logic                     sys_clk = 1'b0;
    logic                     ce = 1'b1;
    logic                     rst_n = 1'b0;
    logic                     reg_wr = 1'b0;
    logic                     reg_rd = 1'b0;
    logic                     tr_valid = 1'b0;
    logic                     evt0 = 1'b0;
    logic                     slow = 1'b0;
    logic [7:0]               reg_addr = 8'h00;
    logic [31:0]              reg_wdata = 32'h0;
    logic [31:0]              reg_rdata;
    tcb_pkg::tcb_word_t       tr_word = '0;
    tcb_pkg::tcb_word_t       mem_data;
    tcb_pkg::tcb_word_t       last_data;
    logic                     tr_ready, mem_valid, mem_ready, mem_ns, irq;
    logic [tcb_pkg::PA_W-1:0] mem_addr, last_addr;
    logic [3:0]               mem_stream;
    int                       cnt, n0, i;
    int                       failures = 0;
    int                       checked = 0;
    tcb_row_t                 rows [9];

    // 40 MHz clock
    always #12.5 sys_clk = ~sys_clk;

    tcb_capture dut_u (.sys_clk(sys_clk), .ce(ce), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .tr_valid(tr_valid), .tr_word(tr_word), .tr_ready(tr_ready), .evt0(evt0),
        .mem_valid(mem_valid), .mem_addr(mem_addr), .mem_data(mem_data),
        .mem_stream(mem_stream), .mem_ns(mem_ns), .mem_ready(mem_ready), .irq(irq));
    tcb_mem_model mem_u (.sys_clk(sys_clk), .rst_n(rst_n), .slow(slow),
        .mem_valid(mem_valid), .mem_addr(mem_addr), .mem_data(mem_data),
        .mem_ready(mem_ready), .last_addr(last_addr), .last_data(last_data), .cnt(cnt));

    task automatic chk(input logic [39:0] got, input logic [39:0] exp);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge sys_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= v;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask : wr
    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge sys_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        chk({8'h0, reg_rdata}, {8'h0, e});
    endtask : rd
    // Word held until taken; a lost handshake counts as a mismatch
    task automatic send(input logic [6:0] id, input logic [24:0] v);
        int n;
        @(posedge sys_clk);
        tr_valid <= 1'b1;
        tr_word  <= '{id: id, data: v};
        for (n = 0; n < 50; n++) begin
            #1;
            if (tr_ready === 1'b1) break;
            @(posedge sys_clk);
        end
        if (n == 50) chk(40'(tr_ready), 40'h1);
        @(posedge sys_clk);
        tr_valid <= 1'b0;
    endtask : send
    task automatic put(input logic [6:0] id, input logic [24:0] v, input logic [39:0] a);
        int c;
        c = cnt;
        send(id, v);
        for (int k = 0; k < 20 && cnt == c; k++) begin
            @(posedge sys_clk);
            #1;
        end
        chk(last_addr, a);
        chk({8'h0, last_data}, {8'h0, id, v});
    endtask : put
    task automatic run_rows();
        foreach (rows[k]) begin
            wr(rows[k].addr, rows[k].wdata);
            rd(rows[k].addr, rows[k].exp);
        end
    endtask : run_rows
    task automatic results();
        $display("checked=%0d failures=%0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : results

    // Watchdog well beyond the expected run length
    initial begin
        repeat (40000) @(posedge sys_clk);
        failures++;
        results();
    end

    initial begin
        rows = '{'{tcb_pkg::OFS_CTRL, 32'h0, 32'h0}, '{tcb_pkg::OFS_BASEL, 32'h12345670,
            32'h12345670}, '{tcb_pkg::OFS_BASEH, 32'hab, 32'hab}, '{tcb_pkg::OFS_SIZE, 32'h4,
            32'h4}, '{tcb_pkg::OFS_WMARK, 32'h3, 32'h3}, '{tcb_pkg::OFS_MASK, 32'h1, 32'h1},
            '{tcb_pkg::OFS_WPTR, 32'hffff, 32'h0}, '{tcb_pkg::OFS_FILL, 32'hffff, 32'h0},
            '{8'h30, 32'hffffffff, 32'h0}};
        repeat (20) @(posedge sys_clk);
        rst_n <= 1'b1;
        run_rows();
        // Second reset in mid-run restores defaults
        @(posedge sys_clk);
        rst_n <= 1'b0;
        repeat (3) @(posedge sys_clk);
        rst_n <= 1'b1;
        rd(tcb_pkg::OFS_CTRL, 32'h04);
        rd(tcb_pkg::OFS_SIZE, 32'h40);
        rd(tcb_pkg::OFS_WMARK, 32'h40);
        run_rows();
        // Contiguous circular buffer against a slow memory
        @(posedge sys_clk);
        slow <= 1'b1;
        wr(tcb_pkg::OFS_CTRL, 32'h05);
        for (i = 0; i < 5; i++) begin
            put(7'(i + 1), 25'(i), 40'hab12345670 + 40'(4 * (i % 4)));
            if (i == 2) chk(40'(irq), 40'h0);
        end
        rd(tcb_pkg::OFS_STS, 32'h3);
        chk(40'(irq), 40'h1);
        rd(tcb_pkg::OFS_WPTR, 32'h1);
        rd(tcb_pkg::OFS_FILL, 32'h4);
        chk(40'({mem_ns, mem_stream}), 40'h11);
        wr(tcb_pkg::OFS_STS, 32'h1);
        rd(tcb_pkg::OFS_STS, 32'h2);
        chk(40'(irq), 40'h0);
        // Scattered pages: word 1024 moves to the second page
        @(posedge sys_clk);
        slow <= 1'b0;
        wr(tcb_pkg::OFS_CTRL, 32'h0);
        wr(tcb_pkg::OFS_SIZE, 32'h800);
        wr(8'h40, 32'h0aaaaaa);
        wr(8'h44, 32'h0bbbbbb);
        wr(tcb_pkg::OFS_CTRL, 32'h0d);
        for (i = 0; i < 1025; i++)
            put(7'h2, 25'(i), i < 1024 ? {28'h0aaaaaa, 10'(i), 2'h0} : 40'h0bbbbbb000);
        // Trigger id stops capture and is not stored
        wr(tcb_pkg::OFS_CTRL, 32'h0);
        wr(tcb_pkg::OFS_SIZE, 32'h4);
        wr(tcb_pkg::OFS_STS, 32'h7);
        wr(tcb_pkg::OFS_MASK, 32'h4);
        wr(tcb_pkg::OFS_CTRL, 32'h15);
        n0 = cnt;
        send(tcb_pkg::TRIG_ID, 25'h1);
        send(7'h3, 25'h2);
        repeat (4) @(posedge sys_clk);
        chk(40'(cnt), 40'(n0));
        rd(tcb_pkg::OFS_STS, 32'hc);
        chk(40'(irq), 40'h1);
        // Dedicated event line, after enabling clears the stop
        wr(tcb_pkg::OFS_CTRL, 32'h04);
        wr(tcb_pkg::OFS_STS, 32'h7);
        wr(tcb_pkg::OFS_CTRL, 32'h15);
        rd(tcb_pkg::OFS_STS, 32'h0);
        @(posedge sys_clk);
        evt0 <= 1'b1;
        @(posedge sys_clk);
        evt0 <= 1'b0;
        rd(tcb_pkg::OFS_STS, 32'hc);
        // Linear mode stops at the end without a wrap flag
        wr(tcb_pkg::OFS_CTRL, 32'h0);
        wr(tcb_pkg::OFS_SIZE, 32'h2);
        wr(tcb_pkg::OFS_STS, 32'h7);
        wr(tcb_pkg::OFS_MASK, 32'h1);
        wr(tcb_pkg::OFS_CTRL, 32'h1);
        put(7'h4, 25'h10, 40'hab12345670);
        put(7'h4, 25'h11, 40'hab12345674);
        n0 = cnt;
        send(7'h4, 25'h12);
        repeat (4) @(posedge sys_clk);
        chk(40'(cnt), 40'(n0));
        rd(tcb_pkg::OFS_STS, 32'h8);
        chk(40'(irq), 40'h0);
        // Local RAM keeps id beside payload and never touches memory
        wr(tcb_pkg::OFS_CTRL, 32'h0);
        wr(tcb_pkg::OFS_SIZE, 32'h4);
        wr(tcb_pkg::OFS_CTRL, 32'h07);
        send(7'h9, 25'h1abcd);
        send(7'ha, 25'h0beef);
        wr(tcb_pkg::OFS_RAMRD, 32'h0);
        rd(tcb_pkg::OFS_RAMRD, {7'h9, 25'h1abcd});
        rd(tcb_pkg::OFS_RAMRD, {7'ha, 25'h0beef});
        // Frozen clock enable holds a waiting word until it returns
        @(posedge sys_clk);
        ce <= 1'b0;
        fork
            send(7'hb, 25'h3);
            begin
                repeat (3) @(posedge sys_clk);
                ce <= 1'b1;
            end
        join
        rd(tcb_pkg::OFS_WPTR, 32'h3);
        rd(tcb_pkg::OFS_RAMRD, {7'hb, 25'h3});
        chk(40'(cnt), 40'(n0));
        results();
    end
endmodule : testbench
